/* hdl/e1dm_defs.vh */
`ifndef E1DM_DEFS_VH
`define E1DM_DEFS_VH

// register byte addresses on the apb bus
`define E1DM_ADDR_STATUS   8'h00
`define E1DM_ADDR_FRAMING  8'h04
`define E1DM_ADDR_ENABLE   8'h08
`define E1DM_ADDR_EVT      8'h0c
`define E1DM_ADDR_EVT_EN   8'h10
`define E1DM_ADDR_EVT_CLR  8'h14

// status register bit positions
`define E1DM_BIT_OOF       7
`define E1DM_BIT_AIS       6
`define E1DM_BIT_MYEL      5
`define E1DM_BIT_LOS       4

// framing control fields
`define E1DM_ALIGNMENT_LOSS_CRITERION_LSB      0
`define E1DM_ALIGNMENT_LOSS_CRITERION_RST      3'h4

// enable register fields
`define E1DM_EN_BLOCK      1
`define E1DM_EN_MYEL       0

// event register bit positions
`define E1DM_EVT_OOF       0
`define E1DM_EVT_AIS       1
`define E1DM_EVT_MYEL      2
`define E1DM_EVT_LOS       3

// timing figures
`define E1DM_E1_BITS_FRAME 256
`define E1DM_AIS_TIME_US   250
`define E1DM_AIS_FRAMES    2
`define E1DM_LOS_BITS      175
`define E1DM_AIS_MAXZ      2

`endif

/* hdl/e1dm_ais_detect.v */
`timescale 1ns/100ps
`include "e1dm_defs.vh"

module e1dm_ais_detect #(
  parameter FRAME_BITS = `E1DM_E1_BITS_FRAME,
  parameter NFRAMES    = `E1DM_AIS_FRAMES
) (
  // clock and reset
  input  wire pclk,
  input  wire presetn,
  // received bit stream
  input  wire bit_valid,
  input  wire bit_data,
  // defect state
  output reg  ais_state
);

  reg [8:0] bit_cnt;
  reg [7:0] zero_cnt;
  reg [1:0] allone_run;
  reg [1:0] zeros_run;
  wire      frame_end = bit_valid && (bit_cnt == FRAME_BITS - 1);
  wire [7:0] next_zero = zero_cnt + {7'h00, ~bit_data};
  wire      many_zero = next_zero > `E1DM_AIS_MAXZ;

  // frames are counted on a free bit grid; ais is unframed so no alignment exists
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bit_cnt    <= 9'h000;
      zero_cnt   <= 8'h00;
      allone_run <= 2'h0;
      zeros_run  <= 2'h0;
      ais_state  <= 1'b0;
    end
    else if (bit_valid)
    begin
      if (frame_end)
      begin
        bit_cnt  <= 9'h000;
        zero_cnt <= 8'h00;
        if (many_zero)
        begin
          allone_run <= 2'h0;
          if (zeros_run != 2'h3)
            zeros_run <= zeros_run + 2'h1;
          if (ais_state && zeros_run + 2'h1 >= NFRAMES)
            ais_state <= 1'b0;
        end
        else
        begin
          zeros_run <= 2'h0;
          if (allone_run != 2'h3)
            allone_run <= allone_run + 2'h1;
          if (allone_run + 2'h1 >= NFRAMES)
            ais_state <= 1'b1;
        end
      end
      else
      begin
        bit_cnt  <= bit_cnt + 9'h001;
        if (zero_cnt != 8'hff)
          zero_cnt <= next_zero;
      end
    end
  end

endmodule // e1dm_ais_detect

/* hdl/e1dm_monitor.v */
`timescale 1ns/100ps
`include "e1dm_defs.vh"

module e1dm_monitor #(
  parameter LOS_BITS = `E1DM_LOS_BITS
) (
  // apb slave
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // receive line, asynchronous to pclk
  input  wire        rx_bit_valid,
  input  wire        rx_bit_data,
  input  wire        rx_fas_check,
  input  wire        rx_fas_error,
  input  wire        rx_mf0_ts16,
  input  wire        rx_y_bit,
  // interrupt
  output reg         irq
);

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers: one flop stage feeding only the second

  localparam NSYNC = 6;
  wire [NSYNC-1:0] async_in = {rx_bit_valid, rx_bit_data, rx_fas_check,
                               rx_fas_error, rx_mf0_ts16, rx_y_bit};
  reg  [NSYNC-1:0] sync_a;
  reg  [NSYNC-1:0] sync_b;
  reg              valid_d;

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi = gi + 1)
    begin : g_sync
      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          sync_a[gi] <= 1'b0;
          sync_b[gi] <= 1'b0;
        end
        else
        begin
          sync_a[gi] <= async_in[gi];
          sync_b[gi] <= sync_a[gi];
        end
      end
    end
  endgenerate

  // strobes are toggled by the line side so every edge is one new bit
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      valid_d <= 1'b0;
    else
      valid_d <= sync_b[5];
  end

  // the line may idle at either level; strobes are ignored until the first
  // synchronised sample has reached valid_d, so reset gives no false bit
  reg [1:0] sync_age;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sync_age <= 2'h0;
    else if (sync_age != 2'h3)
      sync_age <= sync_age + 2'h1;
  end

  wire bit_stb  = (sync_b[5] ^ valid_d) && (sync_age == 2'h3);
  wire bit_data = sync_b[4];
  wire fas_chk  = bit_stb && sync_b[3];
  wire fas_err  = sync_b[2];
  wire mf0_ts16 = bit_stb && sync_b[1];
  wire y_bit    = sync_b[0];

  ////////////////////////////////////////////////////////////////////////////
  // control registers

  reg  [2:0] alignment_loss_criterion;
  reg  [1:0] enable_reg;
  reg  [3:0] evt_enable;
  reg  [3:0] evt_status;
  reg        rx_multiframe_yellow_change;
  reg        rx_frame_loss_state;
  reg        rx_signal_loss_state;
  reg        myel_state;
  wire       rx_alarm_indication_state;

  wire acc      = psel && penable && pready;
  wire wr       = acc && pwrite;
  wire rd       = acc && !pwrite;
  wire rd_stat  = rd && (paddr == `E1DM_ADDR_STATUS);

  ////////////////////////////////////////////////////////////////////////////
  // out-of-frame: count consecutive errored alignment patterns

  reg [2:0] fas_err_run;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fas_err_run         <= 3'h0;
      rx_frame_loss_state <= 1'b0;
    end
    else if (fas_chk)
    begin
      if (fas_err)
      begin
        if (fas_err_run != 3'h7)
          fas_err_run <= fas_err_run + 3'h1;
        if (fas_err_run + 3'h1 >= alignment_loss_criterion)
          rx_frame_loss_state <= 1'b1;
      end
      else
      begin
        // a good pattern ends the run and clears the frame loss state at once
        fas_err_run         <= 3'h0;
        rx_frame_loss_state <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // alarm indication

  e1dm_ais_detect u_ais (
    .pclk      (pclk),
    .presetn   (presetn),
    .bit_valid (bit_stb),
    .bit_data  (bit_data),
    .ais_state (rx_alarm_indication_state)
  );

  ////////////////////////////////////////////////////////////////////////////
  // loss of signal: run of zeros declares, ones density over a window clears

  reg [7:0] zero_run;
  reg [7:0] win_cnt;
  reg [7:0] ones_cnt;
  reg [7:0] gap_cnt;
  reg       density_ok;
  wire      win_end = (win_cnt == LOS_BITS - 1);

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      zero_run             <= 8'h00;
      win_cnt              <= 8'h00;
      ones_cnt             <= 8'h00;
      gap_cnt              <= 8'h00;
      density_ok           <= 1'b1;
      rx_signal_loss_state <= 1'b0;
    end
    else if (bit_stb)
    begin
      zero_run <= bit_data ? 8'h00 : ((zero_run == 8'hff) ? 8'hff : zero_run + 8'h01);
      // 12.5 percent density: no gap of more than seven zeros within the window
      gap_cnt  <= bit_data ? 8'h00 : gap_cnt + 8'h01;
      if (!bit_data && gap_cnt >= 8'h07)
        density_ok <= 1'b0;
      if (bit_data)
        ones_cnt <= ones_cnt + 8'h01;
      if (win_end)
      begin
        win_cnt    <= 8'h00;
        ones_cnt   <= 8'h00;
        density_ok <= 1'b1;
        if (rx_signal_loss_state && density_ok && ({ones_cnt, 3'h0} >= LOS_BITS))
          rx_signal_loss_state <= 1'b0;
      end
      else
        win_cnt <= win_cnt + 8'h01;
      // a lone one never clears the defect; only a clean window does
      if (!bit_data && zero_run + 8'h01 >= LOS_BITS)
        rx_signal_loss_state <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // multiframe yellow alarm and its change flag

  wire next_myel   = mf0_ts16 ? y_bit : myel_state;
  wire myel_change = next_myel != myel_state;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      myel_state                  <= 1'b0;
      rx_multiframe_yellow_change <= 1'b0;
    end
    else
    begin
      myel_state <= next_myel;
      // a change in the read cycle survives the read; only a returned 1 is cleared
      if (myel_change)
        rx_multiframe_yellow_change <= 1'b1;
      else if (rd_stat && prdata[`E1DM_BIT_MYEL])
        rx_multiframe_yellow_change <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sticky event bits for all four defects, yellow included

  reg  [3:0] prev_state;
  wire [3:0] cur_state = {rx_signal_loss_state, myel_state,
                          rx_alarm_indication_state, rx_frame_loss_state};
  wire [3:0] evt_set   = cur_state ^ prev_state;
  wire [3:0] evt_clr   = (wr && paddr == `E1DM_ADDR_EVT_CLR) ? pwdata[3:0] : 4'h0;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prev_state <= 4'h0;
      evt_status <= 4'h0;
    end
    else
    begin
      prev_state <= cur_state;
      evt_status <= (evt_status & ~evt_clr) | evt_set;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb register access, zero wait states

  wire [7:0] status_byte = {rx_frame_loss_state, rx_alarm_indication_state,
                            rx_multiframe_yellow_change, rx_signal_loss_state,
                            4'h0};

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      alignment_loss_criterion <= `E1DM_ALIGNMENT_LOSS_CRITERION_RST;
      enable_reg               <= 2'h0;
      evt_enable               <= 4'h0;
      prdata                   <= 32'h00000000;
      pready                   <= 1'b0;
      pslverr                  <= 1'b0;
    end
    else
    begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
      if (psel && !penable)
      begin
        case (paddr)
          `E1DM_ADDR_STATUS  : prdata <= {24'h000000, status_byte};
          `E1DM_ADDR_FRAMING : prdata <= {29'h00000000, alignment_loss_criterion};
          `E1DM_ADDR_ENABLE  : prdata <= {30'h00000000, enable_reg};
          `E1DM_ADDR_EVT     : prdata <= {28'h0000000, evt_status};
          `E1DM_ADDR_EVT_EN  : prdata <= {28'h0000000, evt_enable};
          `E1DM_ADDR_EVT_CLR : prdata <= 32'h00000000;
          default            : pslverr <= 1'b1;
        endcase
      end
      // writes land at the completing edge, as the status clear does
      if (wr)
      begin
        case (paddr)
          `E1DM_ADDR_FRAMING : alignment_loss_criterion <= pwdata[2:0];
          `E1DM_ADDR_ENABLE  : enable_reg <= pwdata[1:0];
          `E1DM_ADDR_EVT_EN  : evt_enable <= pwdata[3:0];
          default            : ;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt pin

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq <= 1'b0;
    else
      irq <= enable_reg[`E1DM_EN_BLOCK] &&
             ((enable_reg[`E1DM_EN_MYEL] && rx_multiframe_yellow_change) ||
              |(evt_status & evt_enable));
  end

endmodule // e1dm_monitor

/* verification/e1dm_monitor_properties.sv */
`timescale 1ns/100ps
module e1dm_monitor_chk (
  // apb
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  // interrupt
  input wire        irq
);
  reg  [1:0] en;
  reg  [2:0] crit;
  reg  [3:0] ee;
  wire       setup;
  assign setup = psel && !penable;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////
  // shadow of the writable fields, taken at the completing edge
  always @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      en   <= 2'h0;
      crit <= 3'h4;
      ee   <= 4'h0;
    end
    else if (psel && penable && pready && pwrite)
    begin
      if (paddr == 8'h10)
        ee <= pwdata[3:0];
      if (paddr == 8'h08)
        en <= pwdata[1:0];
      if (paddr == 8'h04)
        crit <= pwdata[2:0];
    end
  ////////////////////////////////////////////////////////////////
  chk_ready_next: assert property (setup |=> pready && penable)
    else $error("no ready in access cycle");
  chk_ready_only: assert property (pready |-> $past(setup))
    else $error("ready without setup");
  chk_err_unmapped: assert property (setup && paddr > 8'h14 |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  chk_err_none: assert property (setup && paddr <= 8'h14 && paddr[1:0] == 2'h0 |=> !pslverr)
    else $error("mapped access refused");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  chk_irq_gate: assert property (
    irq |-> $past(en[1]) && ($past(en[0]) || $past(ee) != 4'h0))
    else $error("irq without both enables");
  chk_crit_back: assert property (setup && !pwrite && paddr == 8'h04 |=> prdata[2:0] == $past(crit))
    else $error("criterion readback wrong");
  chk_en_back: assert property (setup && !pwrite && paddr == 8'h08 |=> prdata[1:0] == $past(en))
    else $error("enable readback wrong");
endmodule // e1dm_monitor_chk

bind e1dm_monitor e1dm_monitor_chk u_e1dm_monitor_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .irq(irq)
);

/* verification/e1dm_line_model.sv */
`timescale 1ns/100ps
module e1dm_line_model (
  // clock
  input wire pclk,
  // line
  output reg rx_bit_valid,
  output reg rx_bit_data,
  output reg rx_fas_check,
  output reg rx_fas_error,
  output reg rx_mf0_ts16,
  output reg rx_y_bit
);
  initial
  begin
    {rx_bit_valid, rx_bit_data, rx_fas_check} = 3'h0;
    {rx_fas_error, rx_mf0_ts16, rx_y_bit} = 3'h0;
  end
  // 4 cycles of hold on both sides of the toggle, above the 3 the sync needs
  task send(input logic b, input logic [1:0] frame_alignment_pattern, input logic [1:0] mf);
    begin
      @(posedge pclk);
      rx_bit_data  <= b;
      rx_fas_check <= frame_alignment_pattern[1];
      rx_fas_error <= frame_alignment_pattern[0];
      rx_mf0_ts16  <= mf[1];
      rx_y_bit     <= mf[0];
      repeat (4) @(posedge pclk);
      rx_bit_valid <= ~rx_bit_valid;
      repeat (4) @(posedge pclk);
    end
  endtask
  task run(input logic [7:0] p, input int n);
    for (int i = 0; i < n; i++)
      send(p[i % 8], 2'h0, 2'h0);
  endtask
endmodule // e1dm_line_model

/* verification/e1dm_monitor_tb.sv */
`timescale 1ns/100ps
module e1dm_monitor_tb;
  localparam LOSN = 16;
  reg         pclk, presetn, psel, penable, pwrite;
  reg  [7:0]  paddr;
  reg  [31:0] pwdata;
  wire [31:0] prdata;
  wire        pready, pslverr, irq, bv, bd, fc, fe, mf, yb;
  int         failures, comparisons;
  logic [31:0] r;
  logic        e;
  // rows: write, addr, wdata, expected read, expected error
  logic [73:0] rows [9] = '{
    {1'b0, 8'h00, 32'h0, 32'h0, 1'b0}, {1'b0, 8'h04, 32'h0, 32'h4, 1'b0},
    {1'b0, 8'h08, 32'h0, 32'h0, 1'b0}, {1'b0, 8'h0c, 32'h0, 32'h0, 1'b0},
    {1'b0, 8'h40, 32'h0, 32'h0, 1'b1}, {1'b1, 8'h04, 32'h3, 32'h0, 1'b0},
    {1'b0, 8'h04, 32'h0, 32'h3, 1'b0}, {1'b1, 8'h00, 32'hff, 32'h0, 1'b0},
    {1'b0, 8'h00, 32'h0, 32'h0, 1'b0}};
  e1dm_monitor #(.LOS_BITS(LOSN)) u_e1dm_monitor (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_bit_valid(bv), .rx_bit_data(bd), .rx_fas_check(fc), .rx_fas_error(fe),
    .rx_mf0_ts16(mf), .rx_y_bit(yb), .irq(irq));
  e1dm_line_model u_e1dm_line_model (
    .pclk(pclk), .rx_bit_valid(bv), .rx_bit_data(bd), .rx_fas_check(fc),
    .rx_fas_error(fe), .rx_mf0_ts16(mf), .rx_y_bit(yb));
  ////////////////////////////////////////////////////////////////
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    comparisons++;
    if (g !== x)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, x, g);
    end
  endtask
  task test_done;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // read data is taken at the edge where pready is seen high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task st(input logic [7:0] x);
    apb(1'b0, 8'h00, 32'h0);
    chk("status", {24'h0, x}, r);
  endtask
  task irq_is(input logic x, input int n);
    repeat (n) @(posedge pclk);
    chk("irq", {31'h0, x}, {31'h0, irq});
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i])
    begin
      apb(rows[i][73], rows[i][72:65], rows[i][64:33]);
      chk("error", {31'h0, rows[i][0]}, {31'h0, e});
      if (!rows[i][73])
        chk("data", rows[i][32:1], r);
    end
    $display("test registers done");
    repeat (2) u_e1dm_line_model.send(1'b1, 2'h3, 2'h0);
    st(8'h00);
    u_e1dm_line_model.send(1'b1, 2'h3, 2'h0);
    st(8'h80);
    u_e1dm_line_model.send(1'b1, 2'h2, 2'h0);
    st(8'h00);
    apb(1'b0, 8'h0c, 32'h0);
    chk("events", 32'h1, r);
    apb(1'b1, 8'h14, 32'hf);
    apb(1'b0, 8'h0c, 32'h0);
    chk("events", 32'h0, r);
    $display("test frame loss done");
    u_e1dm_line_model.run(8'h00, LOSN - 1);
    st(8'h00);
    u_e1dm_line_model.run(8'h00, 1);
    st(8'h10);
    u_e1dm_line_model.run(8'h55, 3 * LOSN);
    st(8'h00);
    $display("test signal loss done");
    // unframed all ones: fewer than two whole frames, then at least two
    u_e1dm_line_model.run(8'hff, 250);
    st(8'h00);
    u_e1dm_line_model.run(8'hff, 518);
    st(8'h40);
    u_e1dm_line_model.run(8'h55, 200);
    st(8'h40);
    u_e1dm_line_model.run(8'h55, 568);
    st(8'h00);
    $display("test alarm indication done");
    apb(1'b1, 8'h08, 32'h2);
    u_e1dm_line_model.send(1'b1, 2'h0, 2'h3);
    irq_is(1'b0, 4);
    st(8'h20);
    st(8'h00);
    apb(1'b1, 8'h08, 32'h3);
    u_e1dm_line_model.send(1'b1, 2'h0, 2'h2);
    irq_is(1'b1, 4);
    u_e1dm_line_model.send(1'b1, 2'h0, 2'h2);
    st(8'h20);
    irq_is(1'b0, 2);
    u_e1dm_line_model.send(1'b1, 2'h0, 2'h3);
    irq_is(1'b1, 4);
    apb(1'b1, 8'h08, 32'h1);
    irq_is(1'b0, 2);
    st(8'h20);
    $display("test yellow alarm done");
    apb(1'b1, 8'h10, 32'h4);
    apb(1'b1, 8'h08, 32'h2);
    irq_is(1'b1, 2);
    apb(1'b1, 8'h14, 32'h4);
    irq_is(1'b0, 2);
    $display("test event interrupt done");
    // leave the bit toggle high so a false edge after reset would show up
    u_e1dm_line_model.send(1'b1, 2'h0, 2'h3);
    presetn <= 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
    st(8'h00);
    apb(1'b0, 8'h0c, 32'h0);
    chk("events", 32'h0, r);
    apb(1'b0, 8'h04, 32'h0);
    chk("criterion", 32'h4, r);
    irq_is(1'b0, 1);
    $display("test reset done");
    test_done;
  end
  initial
  begin
    repeat (40000) @(posedge pclk);
    failures++;
    test_done;
  end
endmodule // e1dm_monitor_tb
